// File: hdl/mirs_consts.vh
// constants for the interrupt and reset sequencer
// assumes inclusion by bare name from hdl files
`ifndef MIRS_CONSTS_VH
`define MIRS_CONSTS_VH
// vector addresses (high byte location of each pair is +1)
`define MIRS_VEC_RESET 16'h1FFE
`define MIRS_VEC_SWI 16'h1FFC
`define MIRS_VEC_EXT 16'h1FFA
`define MIRS_VEC_T1 16'h1FF8
`define MIRS_VEC_SCI 16'h1FF6
`define MIRS_VEC_SPI 16'h1FF4
`define MIRS_VEC_TWB 16'h1FF2
`define MIRS_VEC_T2 16'h1FF0
// power-up stabilisation, in processor cycles
`define MIRS_POR_CYCLES 4064
// field positions and sizes
`define MIRS_T2CS_LEVEL_BIT 3
`define MIRS_STACK_BYTES 3'h5
`define MIRS_SRC_COUNT 6
// source index (priority order, 0 highest)
`define MIRS_SRC_EXT 0
`define MIRS_SRC_T1 1
`define MIRS_SRC_SCI 2
`define MIRS_SRC_SPI 3
`define MIRS_SRC_TWB 4
`define MIRS_SRC_T2 5
`endif

// File: hdl/mirs_sequencer.v
// interrupt and reset sequencer for an 8-bit processor core
// assumes the core signals instruction boundaries and runs stacking itself
// Contract
// - seven sources: six maskable hardware sources plus software interrupt.
// - taking an interrupt stacks registers, then sets the mask bit.
// - return instruction unstacks registers and resumes normal processing.
// - interrupts wait for instruction end; reset halts at once.
// - at boundary, take source only if mask clear and enabled.
// - reset pin low sets mask, vectors through 1FFE/1FFF.
// - software interrupt ignores mask, vectors through 1FFC/1FFD.
// - hardware pending at software fetch served first; later ones after.
// - external request latched on falling edge, synchronised, vector 1FFA.
// - timer two control bit 3 picks edge or level-and-edge sensing.
// - external latch cleared early in entry; new edges latch again.
// - timer one: capture, compare, overflow flags with enables; vector 1FF8.
// - serial comms: five enabled flags share vector 1FF6.
// - serial peripheral: transfer complete or mode fault; vector 1FF4.
// - two-wire bus event flag when enabled; vector 1FF2.
// - timer two overflow or periodic flag enabled; vector 1FF0.
// - wait stops core clocks, timers run; any interrupt or reset wakes.
// - stop turns oscillator off until external interrupt or reset.
// - hold reset 4064 cycles after power-up.
// - reset pin still low after delay keeps device in reset.
// - watchdog timeout makes internal reset, operating mode kept.
// - entry uses five stack bytes, low pc first; return reverses.
`timescale 1ns/100ps
`default_nettype none
`include "mirs_consts.vh"
module mirs_sequencer
#(
    parameter POR_CYCLES = `MIRS_POR_CYCLES,
    parameter CNT_W = 13
)
(
    input wire clk,
    input wire sys_rst,
    input wire reset_pin_n,
    input wire external_interrupt_pin_n,
    input wire watchdog_reset,
    input wire timer_two_level_sel,
    input wire [2:0] timer_one_flags,
    input wire [2:0] timer_one_enables,
    input wire [4:0] serial_comms_flags,
    input wire [4:0] serial_comms_enables,
    input wire [1:0] serial_peripheral_flags,
    input wire [1:0] serial_peripheral_enables,
    input wire two_wire_event_flag,
    input wire two_wire_enable,
    input wire [1:0] timer_two_flags,
    input wire [1:0] timer_two_enables,
    input wire insn_boundary,
    input wire swi_fetch,
    input wire rti_exec,
    input wire wait_exec,
    input wire stop_exec,
    input wire mask_clear,
    input wire mask_set,
    input wire stack_ack,
    output reg internal_reset,
    output reg interrupt_mask_bit,
    output reg [15:0] vector_addr,
    output reg vector_valid,
    output reg stack_push,
    output reg stack_pull,
    output reg [2:0] stack_index,
    output reg core_clock_en,
    output reg oscillator_en,
    output reg [1:0] operating_mode,
    output wire [5:0] pending_sources
);
    localparam ST_RESET = 3'h0;
    localparam ST_RUN = 3'h1;
    localparam ST_PUSH = 3'h2;
    localparam ST_VECTOR = 3'h3;
    localparam ST_PULL = 3'h4;
    localparam ST_WAIT = 3'h5;
    localparam ST_STOP = 3'h6;
    localparam MODE_RUN = 2'h0;
    localparam MODE_WAIT = 2'h1;
    localparam MODE_STOP = 2'h2;

    // -------------------------------------------------
    // pin synchronisers
    // -------------------------------------------------
    wire reset_pin_sync;
    wire ext_pin_sync;
    mirs_sync3 #(.RESET_VALUE(1'b1)) u_sync_rst
    (
        .clk(clk),
        .sys_rst(sys_rst),
        .async_in(reset_pin_n),
        .sync_out(reset_pin_sync)
    );
    mirs_sync3 #(.RESET_VALUE(1'b1)) u_sync_ext
    (
        .clk(clk),
        .sys_rst(sys_rst),
        .async_in(external_interrupt_pin_n),
        .sync_out(ext_pin_sync)
    );

    // -------------------------------------------------
    // reset sequencing
    // -------------------------------------------------
    reg [CNT_W-1:0] por_count;
    reg por_done;
    wire any_reset = !por_done || !reset_pin_sync || watchdog_reset;
    // sys_rst stands in for power-up; reset pin sampled through the filter
    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            por_count <= {CNT_W{1'b0}};
            por_done <= 1'b0;
        end
        else if (!por_done)
        begin
            if (por_count == POR_CYCLES[CNT_W-1:0] - 1'b1)
                por_done <= 1'b1;
            else
                por_count <= por_count + 1'b1;
        end
    end

    // -------------------------------------------------
    // external request latch and source gating
    // -------------------------------------------------
    reg ext_prev;
    reg ext_latch;
    wire ext_fall = ext_prev && !ext_pin_sync;
    wire ext_level = timer_two_level_sel && !ext_pin_sync;
    reg ext_clear;
    // set wins over clear so an edge during entry is not lost
    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            ext_prev <= 1'b1;
            ext_latch <= 1'b0;
        end
        else
        begin
            ext_prev <= ext_pin_sync;
            if (ext_fall)
                ext_latch <= 1'b1;
            else if (ext_clear || any_reset)
                ext_latch <= 1'b0;
        end
    end

    wire [5:0] src_req;
    assign src_req[`MIRS_SRC_EXT] = ext_latch || ext_level;
    assign src_req[`MIRS_SRC_T1] = |(timer_one_flags & timer_one_enables);
    assign src_req[`MIRS_SRC_SCI] = |(serial_comms_flags & serial_comms_enables);
    assign src_req[`MIRS_SRC_SPI] = |(serial_peripheral_flags & serial_peripheral_enables);
    assign src_req[`MIRS_SRC_TWB] = two_wire_event_flag && two_wire_enable;
    assign src_req[`MIRS_SRC_T2] = |(timer_two_flags & timer_two_enables);
    assign pending_sources = src_req;

    // -------------------------------------------------
    // priority pick
    // -------------------------------------------------
    reg [15:0] hw_vec;
    reg hw_any;
    integer i;
    // lowest index wins; loop walks down so index 0 lands last
    always @*
    begin
        hw_vec = `MIRS_VEC_T2;
        hw_any = 1'b0;
        for (i = `MIRS_SRC_COUNT - 1; i >= 0; i = i - 1)
        begin
            if (src_req[i])
            begin
                hw_any = 1'b1;
                hw_vec = `MIRS_VEC_EXT - {i[14:0], 1'b0};
            end
        end
    end

    // -------------------------------------------------
    // sequencer state
    // -------------------------------------------------
    reg [2:0] state;
    reg swi_pending;
    reg [5:0] swi_snapshot;
    reg [15:0] entry_vec;
    wire hw_take = hw_any && !interrupt_mask_bit;
    wire snap_take = |(swi_snapshot & src_req) && !interrupt_mask_bit;

    // entry pushes five bytes then loads the vector; return pulls five
    always @(posedge clk)
    begin
        if (sys_rst || any_reset)
        begin
            state <= ST_RESET;
            interrupt_mask_bit <= 1'b1;
            vector_addr <= `MIRS_VEC_RESET;
            vector_valid <= 1'b0;
            stack_push <= 1'b0;
            stack_pull <= 1'b0;
            stack_index <= 3'h0;
            swi_pending <= 1'b0;
            swi_snapshot <= 6'h00;
            entry_vec <= `MIRS_VEC_RESET;
            ext_clear <= 1'b0;
            core_clock_en <= 1'b1;
            oscillator_en <= 1'b1;
            internal_reset <= 1'b1;
            if (sys_rst)
                operating_mode <= MODE_RUN;
            else if (!reset_pin_sync || !por_done)
                operating_mode <= MODE_RUN; // pin reset returns to run
        end
        else
        begin
            vector_valid <= 1'b0;
            ext_clear <= 1'b0;
            case (state)
            ST_RESET:
            begin
                internal_reset <= 1'b0;
                vector_addr <= `MIRS_VEC_RESET;
                vector_valid <= 1'b1;
                state <= ST_RUN;
            end
            ST_RUN:
            begin
                if (mask_set)
                    interrupt_mask_bit <= 1'b1;
                else if (mask_clear)
                    interrupt_mask_bit <= 1'b0;
                if (swi_fetch)
                begin
                    swi_pending <= 1'b1;
                    swi_snapshot <= src_req;
                end
                if (insn_boundary)
                begin
                    if (rti_exec)
                    begin
                        state <= ST_PULL;
                        stack_index <= 3'h0;
                        stack_pull <= 1'b1;
                    end
                    else if (swi_pending && !snap_take)
                    begin
                        swi_pending <= 1'b0;
                        swi_snapshot <= 6'h00;
                        entry_vec <= `MIRS_VEC_SWI;
                        state <= ST_PUSH;
                        stack_index <= 3'h0;
                        stack_push <= 1'b1;
                    end
                    else if (hw_take)
                    begin
                        entry_vec <= hw_vec;
                        if (!src_req[`MIRS_SRC_T1] || ext_latch)
                            ext_clear <= ext_latch;
                        state <= ST_PUSH;
                        stack_index <= 3'h0;
                        stack_push <= 1'b1;
                    end
                    else if (wait_exec)
                    begin
                        interrupt_mask_bit <= 1'b0;
                        core_clock_en <= 1'b0;
                        operating_mode <= MODE_WAIT;
                        state <= ST_WAIT;
                    end
                    else if (stop_exec)
                    begin
                        interrupt_mask_bit <= 1'b0;
                        core_clock_en <= 1'b0;
                        oscillator_en <= 1'b0;
                        operating_mode <= MODE_STOP;
                        state <= ST_STOP;
                    end
                end
            end
            ST_PUSH:
            begin
                if (stack_ack)
                begin
                    if (stack_index == `MIRS_STACK_BYTES - 3'h1)
                    begin
                        stack_push <= 1'b0;
                        interrupt_mask_bit <= 1'b1;
                        state <= ST_VECTOR;
                    end
                    else
                        stack_index <= stack_index + 3'h1;
                end
            end
            ST_VECTOR:
            begin
                vector_addr <= entry_vec;
                vector_valid <= 1'b1;
                state <= ST_RUN;
            end
            ST_PULL:
            begin
                if (stack_ack)
                begin
                    if (stack_index == `MIRS_STACK_BYTES - 3'h1)
                    begin
                        stack_pull <= 1'b0;
                        interrupt_mask_bit <= 1'b0;
                        state <= ST_RUN;
                    end
                    else
                        stack_index <= stack_index + 3'h1;
                end
            end
            ST_WAIT:
            begin
                if (hw_any)
                begin
                    core_clock_en <= 1'b1;
                    operating_mode <= MODE_RUN;
                    entry_vec <= hw_vec;
                    ext_clear <= ext_latch;
                    state <= ST_PUSH;
                    stack_index <= 3'h0;
                    stack_push <= 1'b1;
                end
            end
            ST_STOP:
            begin
                if (src_req[`MIRS_SRC_EXT])
                begin
                    core_clock_en <= 1'b1;
                    oscillator_en <= 1'b1;
                    operating_mode <= MODE_RUN;
                    entry_vec <= `MIRS_VEC_EXT;
                    ext_clear <= ext_latch;
                    state <= ST_PUSH;
                    stack_index <= 3'h0;
                    stack_push <= 1'b1;
                end
            end
            default:
                state <= ST_RESET;
            endcase
        end
    end
endmodule // mirs_sequencer
`default_nettype wire

// File: hdl/mirs_sync3.v
// three-stage synchroniser with agreement filter
// assumes async input, single clk domain
`timescale 1ns/100ps
`default_nettype none
module mirs_sync3
#(
    parameter RESET_VALUE = 1'b1
)
(
    input wire clk,
    input wire sys_rst,
    input wire async_in,
    output reg sync_out
);
    reg stage_a;
    reg stage_b;
    reg stage_c;
    // stage_a feeds only stage_b; output moves when b and c agree
    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            stage_a <= RESET_VALUE;
            stage_b <= RESET_VALUE;
            stage_c <= RESET_VALUE;
            sync_out <= RESET_VALUE;
        end
        else
        begin
            stage_a <= async_in;
            stage_b <= stage_a;
            stage_c <= stage_b;
            if (stage_b == stage_c)
                sync_out <= stage_c;
        end
    end
endmodule // mirs_sync3
`default_nettype wire

// File: testbench/mirs_checker.sv
// checker: port timing of the interrupt and reset sequencer
// assumes a bind onto mirs_sequencer, one clock domain
`timescale 1ns/100ps
`default_nettype none
module mirs_checker
(
    input wire clk,
    input wire sys_rst,
    input wire reset_pin_n,
    input wire watchdog_reset,
    input wire stack_ack,
    input wire internal_reset,
    input wire interrupt_mask_bit,
    input wire [15:0] vector_addr,
    input wire vector_valid,
    input wire stack_push,
    input wire [2:0] stack_index,
    input wire oscillator_en,
    input wire [1:0] operating_mode
);
    // ----------------------------------------
    // entry steps, resets and stop mode
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    sequence s_last_byte;
        stack_push && stack_ack && stack_index == 3'h4;
    endsequence
    // mask must be up before the vector is handed over
    sequence s_tail;
        !stack_push && interrupt_mask_bit ##1 vector_valid;
    endsequence
    property p_por;
        $fell(sys_rst) |-> internal_reset && interrupt_mask_bit && vector_addr == 16'h1FFE;
    endproperty
    property p_entry;
        s_last_byte |=> s_tail;
    endproperty
    property p_first;
        $rose(stack_push) |-> stack_index == 3'h0;
    endproperty
    property p_vmask;
        vector_valid |-> interrupt_mask_bit;
    endproperty
    property p_pulse;
        vector_valid |=> !vector_valid;
    endproperty
    property p_wdog;
        watchdog_reset |-> ##[1:4] internal_reset;
    endproperty
    // synchroniser delay leaves a few cycles of slack
    property p_pin;
        !reset_pin_n [*8] |-> internal_reset;
    endproperty
    property p_stop;
        operating_mode == 2'h2 && $stable(operating_mode) |-> !oscillator_en;
    endproperty
    a_por: assert property (p_por) else $error("power reset state wrong");
    a_entry: assert property (p_entry) else $error("entry tail wrong");
    a_first: assert property (p_first) else $error("first stacked byte not index 0");
    a_vmask: assert property (p_vmask) else $error("vector without mask");
    a_pulse: assert property (p_pulse) else $error("vector valid too long");
    a_wdog: assert property (p_wdog) else $error("watchdog gave no reset");
    a_pin: assert property (p_pin) else $error("pin gave no reset");
    a_stop: assert property (p_stop) else $error("oscillator on in stop");
endmodule // mirs_checker
bind mirs_sequencer mirs_checker u_chk (.clk, .sys_rst, .reset_pin_n, .watchdog_reset, .stack_ack,
    .internal_reset, .interrupt_mask_bit, .vector_addr, .vector_valid, .stack_push, .stack_index,
    .oscillator_en, .operating_mode);
`default_nettype wire

// File: testbench/mirs_core_model.sv
// core model: moves stack bytes and acknowledges each one
// assumes push/pull levels from the sequencer, acks at falling edge
`timescale 1ns/100ps
`default_nettype none
module mirs_core_model
(
    input wire logic clk,
    input wire logic stack_push,
    input wire logic stack_pull,
    input wire logic slow,
    output logic stack_ack
);
    // ----------------------------------------
    // byte mover
    // ----------------------------------------
    logic [1:0] gap = 2'h0;
    initial stack_ack = 1'b0;
    // slow mode spaces acks to catch a counter that ignores ack
    always @(negedge clk)
    begin
        gap <= (stack_push | stack_pull) ? gap + 2'h1 : 2'h0;
        stack_ack <= (stack_push | stack_pull) && (!slow || gap == 2'h2);
    end
endmodule // mirs_core_model
`default_nettype wire

// File: testbench/tb_mirs_sequencer.sv
// testbench: sources, boundaries, resets against a queue model
// assumes inputs change at falling edge, POR_CYCLES shortened to 8
`timescale 1ns/100ps
`default_nettype none
module tb_mirs_sequencer;
    logic clk = 1'b0, sys_rst = 1'b1, reset_pin_n = 1'b0, external_interrupt_pin_n = 1'b1;
    logic watchdog_reset = 1'b0, timer_two_level_sel = 1'b0, slow = 1'b0;
    logic [2:0] timer_one_flags = 3'h0, timer_one_enables = 3'h0;
    logic [4:0] serial_comms_flags = 5'h00, serial_comms_enables = 5'h00;
    logic [1:0] serial_peripheral_flags = 2'h0, serial_peripheral_enables = 2'h0;
    logic two_wire_event_flag = 1'b0, two_wire_enable = 1'b0;
    logic [1:0] timer_two_flags = 2'h0, timer_two_enables = 2'h0;
    logic insn_boundary = 1'b0, swi_fetch = 1'b0, rti_exec = 1'b0, wait_exec = 1'b0;
    logic stop_exec = 1'b0, mask_clear = 1'b0, mask_set = 1'b0;
    logic stack_ack, internal_reset, interrupt_mask_bit, vector_valid, stack_push, stack_pull;
    logic core_clock_en, oscillator_en;
    logic [15:0] vector_addr;
    logic [2:0] stack_index;
    logic [1:0] operating_mode;
    logic [5:0] pending_sources;
    logic [15:0] exp_q[$];
    int n_errors = 0, compares = 0, nv = 0, cyc = 0, a, b;
    // ----------------------------------------
    // design and core
    // ----------------------------------------
    mirs_sequencer #(.POR_CYCLES(8)) DUT (.clk, .sys_rst, .reset_pin_n, .external_interrupt_pin_n,
        .watchdog_reset, .timer_two_level_sel, .timer_one_flags, .timer_one_enables, .serial_comms_flags,
        .serial_comms_enables, .serial_peripheral_flags, .serial_peripheral_enables, .two_wire_event_flag,
        .two_wire_enable, .timer_two_flags, .timer_two_enables, .insn_boundary, .swi_fetch, .rti_exec,
        .wait_exec, .stop_exec, .mask_clear, .mask_set, .stack_ack, .internal_reset, .interrupt_mask_bit,
        .vector_addr, .vector_valid, .stack_push, .stack_pull, .stack_index, .core_clock_en,
        .oscillator_en, .operating_mode, .pending_sources);
    mirs_core_model u_core (.clk, .stack_push, .stack_pull, .slow, .stack_ack);
    always #5 clk = ~clk;
    // vector pair low address by source, priority index order
    function logic [15:0] vec(input int s);
        return 16'h1FFA - 16'(2 * s);
    endfunction
    task chk_b(input string nm, input logic e, input logic g);
        compares++;
        if (g !== e)
        begin
            n_errors++;
            $display("wrong value %s expected %b seen %b", nm, e, g);
        end
    endtask
    task chk_v(input string nm, input logic [15:0] e, input logic [15:0] g);
        compares++;
        if (g !== e)
        begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task summarize();
        $display("counts n_errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // every vector handed out must be the next one the model expects
    always @(negedge clk)
        if (vector_valid === 1'b1)
        begin
            nv++;
            chk_v("vector", exp_q.size() > 0 ? exp_q.pop_front() : 16'h0000, vector_addr);
        end
    // hang guard, far above the thousand or so cycles needed
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            n_errors++;
            summarize();
        end
    end
    task tick(input int n);
        repeat (n) @(negedge clk);
    endtask
    task src(input int s, input logic f, input logic e);
        int k;
        k = $urandom_range(4);
        case (s)
            0: external_interrupt_pin_n = !f;
            1: {timer_one_flags, timer_one_enables} = {3'(f) << (k % 3), 3'(e) << (k % 3)};
            2: {serial_comms_flags, serial_comms_enables} = {5'(f) << k, 5'(e) << k};
            3: {serial_peripheral_flags, serial_peripheral_enables} = {2'(f) << (k % 2), 2'(e) << (k % 2)};
            4: {two_wire_event_flag, two_wire_enable} = {f, e};
            default: {timer_two_flags, timer_two_enables} = {2'(f) << (k % 2), 2'(e) << (k % 2)};
        endcase
    endtask
    // one boundary pulse; qualifiers are set by the caller beforehand
    task bnd();
        insn_boundary = 1'b1;
        tick(1);
        {insn_boundary, rti_exec, wait_exec, stop_exec} = 4'h0;
    endtask
    task wv();
        int n0;
        n0 = nv;
        for (int i = 0; i < 300 && nv == n0; i++) tick(1);
        chk_b("vector seen", 1'b1, nv != n0);
    endtask
    task ret();
        rti_exec = 1'b1;
        bnd();
        for (int i = 0; i < 10 && stack_pull !== 1'b1; i++) tick(1);
        for (int i = 0; i < 60 && stack_pull !== 1'b0; i++) tick(1);
        tick(1);
        chk_b("mask after return", 1'b0, interrupt_mask_bit);
    endtask
    task serve(input int s);
        bnd();
        wv();
        src(s, 1'b0, 1'b0);
        ret();
    endtask
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        void'($urandom(18758));
        tick(8);
        sys_rst = 1'b0;
        tick(40);
        chk_b("reset held by pin", 1'b1, internal_reset);
        exp_q.push_back(16'h1FFE);
        reset_pin_n = 1'b1;
        wv();
        chk_b("mask after reset", 1'b1, interrupt_mask_bit);
        src(1, 1'b1, 1'b1);
        bnd();
        tick(2);
        chk_b("push while masked", 1'b0, stack_push);
        mask_clear = 1'b1;
        tick(1);
        mask_clear = 1'b0;
        exp_q.push_back(vec(1));
        serve(1);
        $display("test reset and mask done");
        for (int s = 0; s < 6; s++)
        begin
            slow = s[0];
            timer_two_level_sel = 1'($urandom_range(1));
            src(s, 1'b1, 1'b0);
            tick(6);
            chk_b("pending without enable", s == 0, pending_sources[s]);
            src(s, 1'b1, 1'b1);
            tick(6);
            exp_q.push_back(vec(s));
            serve(s);
        end
        $display("test sources done");
        for (int i = 0; i < 3; i++)
        begin
            a = $urandom_range(5);
            b = (a + 1 + $urandom_range(4)) % 6;
            src(a, 1'b1, 1'b1);
            src(b, 1'b1, 1'b1);
            tick(6);
            exp_q.push_back(vec(a < b ? a : b));
            exp_q.push_back(vec(a < b ? b : a));
            serve(a < b ? a : b);
            serve(a < b ? b : a);
        end
        $display("test priority done");
        src(5, 1'b1, 1'b1);
        tick(6);
        swi_fetch = 1'b1;
        tick(1);
        swi_fetch = 1'b0;
        exp_q.push_back(vec(5));
        exp_q.push_back(16'h1FFC);
        serve(5);
        serve(6);
        mask_set = 1'b1;
        tick(1);
        mask_set = 1'b0;
        swi_fetch = 1'b1;
        tick(1);
        swi_fetch = 1'b0;
        exp_q.push_back(16'h1FFC);
        serve(6);
        $display("test software interrupt done");
        wait_exec = 1'b1;
        bnd();
        tick(2);
        chk_b("core clock in wait", 1'b0, core_clock_en);
        exp_q.push_back(vec(5));
        src(5, 1'b1, 1'b1);
        wv();
        src(5, 1'b0, 1'b0);
        ret();
        stop_exec = 1'b1;
        bnd();
        tick(2);
        chk_b("oscillator in stop", 1'b0, oscillator_en);
        exp_q.push_back(vec(0));
        src(0, 1'b1, 1'b1);
        wv();
        src(0, 1'b0, 1'b0);
        ret();
        $display("test low power done");
        exp_q.push_back(16'h1FFE);
        watchdog_reset = 1'b1;
        tick(1);
        chk_b("watchdog reset", 1'b1, internal_reset);
        watchdog_reset = 1'b0;
        wv();
        chk_b("all vectors seen", 1'b1, exp_q.size() == 0);
        $display("test watchdog done");
        summarize();
    end
endmodule // tb_mirs_sequencer
`default_nettype wire
